// File: hw/bgs_detector.sv
// Block and group sync detector: window, divider, endstop sequencer and flywheel.
// Assumes data_clk_pulse is a one-cycle strobe synchronous to clk, data_bit valid with it.
//
// Operation
// R1: Each data clock, syndrome of the latest 26 bits is computed, oldest first.
// R2: Sync declared on two legal-order offset matches a multiple of 26 bits apart.
// R3: In sync, expected offset is removed before the error syndrome is formed.
// R4: Sync loss decided from errored block count over a 50 block span.
// R5: Known station identifier one bit early or late flags a slip and realigns.
// R6: Window shifts in new data when selected, else recirculates its output.
// R7: Syndrome formed by a 10-bit divider with generator polynomial taps.
// R8: Five match outputs decoded from divider contents, one per offset.
// R9: Fast recirculation clock runs at 33.5 kHz or faster.
// R10: Modulo-28 endstop counter decodes states 0, 1 and 27 for flags; the code decodes only states 0 and 27.
// R11: At state 27 flags B and inhibit set, arrival clear, divider held clear.
// R12: Data clock sets arrival, restarts counter, new bit enters window left end.
// R13: Arrival flag clears on the first fast clock after it was set.
// R14: All 26 stored bits circulate through the divider before next data clock.
// R15: Remainders for A, B, C are 0101111111, 0000001110, 0100101111.
// R16: Remainders for C' and D are 1011101100 and 1010010111.
// R17: Matching remainder gives a sync pulse on that offset's output.
// R18: Whole pass completes within one data bit period of about 842 us.
// R19: Pass repeats each data clock; in sync a pulse marks each block end.
// R20: Matched offset identity also yields group position.
// R21: Flywheel rejects spurious pulses, fills missing ones, keeps A B C/C' D order.
// R22: Counter holds at 27 until the next data clock restarts it.
`timescale 1ns/10ps
module bgs_detector
  import bgs_pkg::*;
#(
  parameter int ERR_LIMIT = ERR_LIMIT_DEF
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic data_clk_pulse,
  input wire logic data_bit,
  input wire logic [15:0] station_id,
  input wire logic station_id_valid,
  output logic [4:0] match_pulse,
  output bgs_status_s status,
  output logic [9:0] err_syndrome
);

  // Fast clock well above minimum, and a pass well inside one bit period
  localparam bit FAST_OK = (CLK_HZ >= FAST_MIN_HZ) && (PASS_CYC < BIT_PERIOD_CYC); // R9 R18
  localparam logic [5:0] ERR_LIM_V = 6'(ERR_LIMIT);

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer, window and divider state
  logic [4:0] cnt_r, cnt_nxt;
  logic data_arrival_flag_r, data_arrival_flag_nxt;
  logic sequencer_flag_b_r, sequencer_flag_b_nxt;
  logic fast_clock_inhibit_flag_r, fast_clock_inhibit_flag_nxt;
  logic bit_r, bit_nxt;
  logic [25:0] win_r, win_nxt;
  logic [9:0] syn_r, syn_nxt;
  logic overrun_r, overrun_nxt;
  logic st0, st27, dividing, compare;
  logic fb;

  assign st0 = (cnt_r == 5'h00);
  assign st27 = (cnt_r == CNT_TOP_V);
  assign dividing = !st0 && !st27 && FAST_OK;
  assign compare = st27 && !sequencer_flag_b_r;
  assign fb = syn_r[9] ^ win_r[0];

  always_comb
  begin
    cnt_nxt = cnt_r;
    data_arrival_flag_nxt = data_arrival_flag_r;
    sequencer_flag_b_nxt = sequencer_flag_b_r;
    fast_clock_inhibit_flag_nxt = fast_clock_inhibit_flag_r;
    bit_nxt = bit_r;
    win_nxt = win_r;
    syn_nxt = syn_r;
    overrun_nxt = 1'b0;
    if (data_clk_pulse)
    begin
      // A pulse mid-pass restarts the pass; the late result is dropped
      overrun_nxt = !st27;
      data_arrival_flag_nxt = 1'b1; // R12
      cnt_nxt = 5'h00; // R12
      fast_clock_inhibit_flag_nxt = 1'b0; // R12
      sequencer_flag_b_nxt = 1'b0;
      bit_nxt = data_bit;
      syn_nxt = '0;
    end
    else if (st0)
    begin
      data_arrival_flag_nxt = 1'b0; // R13
      win_nxt = {bit_r, win_r[25:1]}; // R6 R12
      syn_nxt = '0; // R12
      cnt_nxt = 5'h01; // R10
    end
    else if (dividing)
    begin
      win_nxt = {win_r[0], win_r[25:1]}; // R6 R14
      syn_nxt = {syn_r[8:0], 1'b0} ^ (fb ? GEN_TAPS : 10'h000); // R7 R1 R14
      cnt_nxt = cnt_r + 5'h01; // R10
    end
    else
    begin
      // Endstop: hold until the next data clock
      cnt_nxt = CNT_TOP_V; // R22
      data_arrival_flag_nxt = 1'b0; // R11
      sequencer_flag_b_nxt = 1'b1; // R11
      fast_clock_inhibit_flag_nxt = 1'b1; // R11
      if (sequencer_flag_b_r)
      begin
        syn_nxt = '0; // R11
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_r <= CNT_TOP_V;
      data_arrival_flag_r <= 1'b0;
      sequencer_flag_b_r <= 1'b1;
      fast_clock_inhibit_flag_r <= 1'b1;
      bit_r <= 1'b0;
      win_r <= '0;
      syn_r <= '0;
      overrun_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      data_arrival_flag_r <= data_arrival_flag_nxt;
      sequencer_flag_b_r <= sequencer_flag_b_nxt;
      fast_clock_inhibit_flag_r <= fast_clock_inhibit_flag_nxt;
      bit_r <= bit_nxt;
      win_r <= win_nxt;
      syn_r <= syn_nxt;
      overrun_r <= overrun_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Offset decode
  logic [4:0] hit;
  logic [2:0] hit_off;
  logic [1:0] hit_pos;
  logic any_hit;
  logic [15:0] info;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_OFFSETS; gi++)
    begin : g_dec
      assign hit[gi] = compare && (syn_r == SYN_TAB[gi]); // R8 R15 R16
    end
    for (gi = 0; gi < INFO_BITS; gi++)
    begin : g_info
      // Oldest window bit is the first information bit
      assign info[15 - gi] = win_r[gi];
    end
  endgenerate

  always_comb
  begin
    hit_off = 3'(OFF_A);
    for (int i = NUM_OFFSETS - 1; i >= 0; i--)
    begin
      if (hit[i])
      begin
        hit_off = 3'(i);
      end
    end
  end

  assign any_hit = |hit;
  // C and C' share a group slot
  assign hit_pos = (hit_off == 3'(OFF_A)) ? 2'h0 :
                   (hit_off == 3'(OFF_B)) ? 2'h1 :
                   (hit_off == 3'(OFF_D)) ? 2'h3 : 2'h2; // R20

  ////////////////////////////////////////////////////////////////////////////
  // Acquisition and flywheel
  bgs_track_e trk_r, trk_nxt;
  logic [4:0] phase_r, phase_nxt;
  logic [1:0] roll_r, roll_nxt;
  logic [5:0] span_r, span_nxt;
  logic [5:0] errs_r, errs_nxt;
  logic [4:0] match_nxt;
  logic [9:0] esyn_nxt;
  bgs_status_s st_nxt;
  logic [4:0] ph_inc;
  logic [1:0] roll_inc;
  logic [2:0] exp_off;
  logic [9:0] exp_syn;
  logic id_ok;

  assign ph_inc = (phase_r == PHASE_LAST) ? 5'h00 : phase_r + 5'h01;
  assign roll_inc = (phase_r == PHASE_LAST) ? roll_r + 2'h1 : roll_r;
  assign id_ok = station_id_valid && hit[OFF_A] && (info == station_id);

  always_comb
  begin
    // C' is taken when seen, otherwise C is assumed for slot 2
    case (roll_inc)
      2'h0: exp_off = 3'(OFF_A);
      2'h1: exp_off = 3'(OFF_B);
      2'h2: exp_off = hit[OFF_CP] ? 3'(OFF_CP) : 3'(OFF_C);
      2'h3: exp_off = 3'(OFF_D);
      default: exp_off = 3'(OFF_A);
    endcase
    exp_syn = SYN_TAB[exp_off];
  end

  always_comb
  begin
    trk_nxt = trk_r;
    phase_nxt = phase_r;
    roll_nxt = roll_r;
    span_nxt = span_r;
    errs_nxt = errs_r;
    match_nxt = hit; // R17
    esyn_nxt = err_syndrome;
    st_nxt = status;
    st_nxt.block_end = 1'b0;
    st_nxt.block_error = 1'b0;
    st_nxt.sync_lost = 1'b0;
    st_nxt.slip = 1'b0;
    st_nxt.overrun = overrun_r;
    if (compare)
    begin
      phase_nxt = ph_inc; // R19
      roll_nxt = roll_inc;
      case (trk_r)
        TRK_HUNT:
        begin
          if (any_hit)
          begin
            trk_nxt = TRK_ARMED;
            phase_nxt = 5'h00;
            roll_nxt = hit_pos;
          end
        end
        TRK_ARMED:
        begin
          if (any_hit && ph_inc == 5'h00 && hit_pos == roll_inc)
          begin
            trk_nxt = TRK_SYNC; // R2
            span_nxt = '0;
            errs_nxt = '0;
          end
          else if (any_hit)
          begin
            phase_nxt = 5'h00;
            roll_nxt = hit_pos;
          end
        end
        TRK_SYNC:
        begin
          if (id_ok && (ph_inc == PHASE_LAST || ph_inc == 5'h01))
          begin
            // One bit slip: realign to this block A at once
            phase_nxt = 5'h00; // R5
            roll_nxt = 2'h0; // R5
            st_nxt.slip = 1'b1; // R5
            st_nxt.block_end = 1'b1;
            st_nxt.offset = 3'(OFF_A);
            st_nxt.group_pos = 2'h0;
          end
          else if (ph_inc == 5'h00)
          begin
            // Flywheel block end, whether or not the raw pulse came
            esyn_nxt = syn_r ^ exp_syn; // R3
            st_nxt.block_end = 1'b1; // R21
            st_nxt.offset = exp_off; // R21 R20
            st_nxt.group_pos = roll_inc; // R20
            st_nxt.block_error = (syn_r != exp_syn); // R3 R21
            errs_nxt = errs_r + ((syn_r != exp_syn) ? 6'h01 : 6'h00); // R4
            span_nxt = span_r + 6'h01;
            // Give up as soon as the span's error budget is spent, not at its end
            if (errs_nxt > ERR_LIM_V)
            begin
              trk_nxt = TRK_HUNT; // R4
              st_nxt.sync_lost = 1'b1;
              span_nxt = '0;
              errs_nxt = '0;
            end
            else if (span_r == SPAN_LAST)
            begin
              span_nxt = '0; // R4
              errs_nxt = '0;
            end
          end
        end
        default:
        begin
          trk_nxt = TRK_HUNT;
        end
      endcase
    end
    st_nxt.synced = (trk_nxt == TRK_SYNC);
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      trk_r <= TRK_HUNT;
      phase_r <= '0;
      roll_r <= '0;
      span_r <= '0;
      errs_r <= '0;
      match_pulse <= '0;
      err_syndrome <= '0;
      status <= '0;
    end
    else
    begin
      trk_r <= trk_nxt;
      phase_r <= phase_nxt;
      roll_r <= roll_nxt;
      span_r <= span_nxt;
      errs_r <= errs_nxt;
      match_pulse <= match_nxt;
      err_syndrome <= esyn_nxt;
      status <= st_nxt;
    end
  end

endmodule

// File: hw/bgs_pkg.sv
// Constants, offset syndromes and carrier types for the block/group sync detector.
// Assumes one 50 MHz clock that doubles as the fast recirculation clock.
package bgs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Geometry and timing
  localparam int BLOCK_BITS = 26;
  localparam int SYN_BITS = 10;
  localparam int INFO_BITS = 16;
  localparam int CNT_TOP = 27;
  localparam int SPAN_BLOCKS = 50;
  localparam int CLK_HZ = 50000000;
  localparam int FAST_MIN_HZ = 33500;
  localparam int BIT_PERIOD_NS = 842000;
  localparam int CLK_PERIOD_NS = 1000000000 / CLK_HZ;
  localparam int BIT_PERIOD_CYC = BIT_PERIOD_NS / CLK_PERIOD_NS;
  localparam int PASS_CYC = CNT_TOP + 1;
  localparam int ERR_LIMIT_DEF = 10;

  localparam logic [4:0] CNT_TOP_V = 5'h1B;
  localparam logic [4:0] CNT_LAST_DIV = 5'h1A;
  localparam logic [4:0] PHASE_LAST = 5'h19;
  localparam logic [5:0] SPAN_LAST = 6'h31;

  // Generator feedback taps, x^10 term implied
  localparam logic [9:0] GEN_TAPS = 10'h1B9;

  ////////////////////////////////////////////////////////////////////////////
  // Offsets and their divider remainders
  typedef enum logic [2:0]
  {
    OFF_A = 3'h0,
    OFF_B = 3'h1,
    OFF_C = 3'h2,
    OFF_CP = 3'h3,
    OFF_D = 3'h4
  } bgs_offset_e;

  localparam int NUM_OFFSETS = 5;
  // Index order A, B, C, C', D
  localparam logic [4:0][9:0] SYN_TAB = {10'h297, 10'h2EC, 10'h12F, 10'h00E, 10'h17F};

  typedef enum logic [1:0]
  {
    TRK_HUNT = 2'h0,
    TRK_ARMED = 2'h1,
    TRK_SYNC = 2'h2
  } bgs_track_e;

  typedef struct packed {
    logic synced;
    logic block_end;
    logic [2:0] offset;
    logic [1:0] group_pos;
    logic block_error;
    logic sync_lost;
    logic slip;
    logic overrun;
  } bgs_status_s;

endpackage

// File: testbench/bgs_demod_model.sv
// Demodulator stand-in: one strobe per recovered bit.
// Assumes the caller spaces bits as the detector needs.
`timescale 1ns/10ps
module bgs_demod_model
(
  input wire logic clk,
  output logic data_clk_pulse,
  output logic data_bit
);
  initial
  begin
    data_clk_pulse = 1'b0;
    data_bit = 1'b0;
  end
  // Idle edges first model a slow demodulator
  task automatic send(input logic b, input int idle);
    repeat (idle) @(posedge clk);
    @(posedge clk);
    data_clk_pulse <= 1'b1;
    data_bit <= b;
    @(posedge clk);
    data_clk_pulse <= 1'b0;
    // Inverse, so a late sample cannot pass by luck
    data_bit <= ~b;
  endtask
endmodule

// File: testbench/bgs_detector_checker.sv
// Port assertions for the block/group sync detector.
// Assumes one clock and an async active-high reset.
`timescale 1ns/10ps
module bgs_detector_checker
  import bgs_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic data_clk_pulse,
  input wire logic [4:0] match_pulse,
  input wire bgs_status_s status,
  input wire logic [9:0] err_syndrome
);
  // Edges since the last strobe, saturating
  logic [4:0] gap_r;
  logic [4:0] gap_nxt;
  always_comb
  begin
    gap_nxt = gap_r;
    if (data_clk_pulse)
      gap_nxt = 5'h01;
    else if (gap_r != 5'h1F)
      gap_nxt = gap_r + 5'h01;
  end
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      gap_r <= 5'h1F;
    else
      gap_r <= gap_nxt;
  end
  ////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_onehot;
    $onehot0(match_pulse);
  endproperty
  a_onehot: assert property (p_onehot) else $error("two matches");
  // A result seen here came from an uninterrupted pass
  property p_match_t;
    |match_pulse |-> gap_r == 5'h1D || (gap_r == 5'h01 && $past(gap_r) == 5'h1C);
  endproperty
  a_match_t: assert property (p_match_t) else $error("match timing");
  property p_end_t;
    status.block_end |-> gap_r == 5'h1D || (gap_r == 5'h01 && $past(gap_r) == 5'h1C);
  endproperty
  a_end_t: assert property (p_end_t) else $error("block end timing");
  property p_ovr;
    data_clk_pulse && gap_r < 5'h1C |-> ##2 status.overrun;
  endproperty
  a_ovr: assert property (p_ovr) else $error("no overrun");
  property p_gpos;
    status.block_end |-> status.group_pos == (status.offset == OFF_D ? 2'h3 :
      status.offset == OFF_CP ? 2'h2 : status.offset[1:0]);
  endproperty
  a_gpos: assert property (p_gpos) else $error("group position");
  property p_esyn;
    $changed(err_syndrome) |-> status.block_end;
  endproperty
  a_esyn: assert property (p_esyn) else $error("syndrome moved");
  property p_slip;
    status.slip |-> status.block_end && status.offset == OFF_A;
  endproperty
  a_slip: assert property (p_slip) else $error("slip without A");
  property p_lost;
    status.sync_lost |=> !status.synced;
  endproperty
  a_lost: assert property (p_lost) else $error("still synced");
  c_match: cover property (match_pulse[0]);
  c_end: cover property (status.block_end && status.synced);
  c_ovr: cover property (status.overrun);
  c_slip: cover property (status.slip);
endmodule
bind bgs_detector bgs_detector_checker u_chk (.clk(clk), .rst(rst),
  .data_clk_pulse(data_clk_pulse), .match_pulse(match_pulse), .status(status),
  .err_syndrome(err_syndrome));

// File: testbench/block_group_sync_detector_tb.sv
// Self-checking bench for the sync detector.
// Assumes the demodulator model and the bound checker.
`timescale 1ns/10ps
module block_group_sync_detector_tb
  import bgs_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic dcp;
  logic db;
  logic [4:0] mp;
  bgs_status_s st;
  logic [9:0] es;
  logic [25:0] win = '0;
  logic chk_end = 1'b0;
  logic exp_lost = 1'b0;
  logic exp_slip = 1'b0;
  logic sidv = 1'b0;
  logic [15:0] sid = 16'h6D2B;
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0;
  int nb = 0;
  // Offset words and remainders, order A B C C' D
  logic [9:0] ow [5] = '{10'h0FC, 10'h198, 10'h168, 10'h350, 10'h1B4};
  logic [9:0] sy [5] = '{10'h17F, 10'h00E, 10'h12F, 10'h2EC, 10'h297};
  always #10 clk = ~clk;
  bgs_detector #(.ERR_LIMIT(2)) DUT (.clk(clk), .rst(rst), .data_clk_pulse(dcp),
    .data_bit(db), .station_id(sid), .station_id_valid(sidv),
    .match_pulse(mp), .status(st), .err_syndrome(es));
  bgs_demod_model DEM (.clk(clk), .data_clk_pulse(dcp), .data_bit(db));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [9:0] div(logic [25:0] w, int n);
    logic [9:0] r;
    r = '0;
    for (int i = 25; i > 25 - n; i--)
      r = {r[8:0], 1'b0} ^ ((w[i] ^ r[9]) ? GEN_TAPS : 10'h000);
    return r;
  endfunction
  task automatic cmp(string nm, logic [31:0] e, logic [31:0] s);
    n_tests++;
    if (s !== e)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic bit_out(logic b, int k, logic last, logic fl);
    logic [9:0] s;
    logic [4:0] e;
    DEM.send(b, nb % 3 * 5);
    nb++;
    win = {win[24:0], b};
    s = div(win, 26);
    for (int j = 0; j < 5; j++)
      e[j] = (s == sy[j]);
    repeat (28) @(posedge clk);
    #1;
    if (nb >= 26)
      cmp("match", 32'(e), 32'(mp));
    cmp("slip", 32'(exp_slip & last), 32'(st.slip));
    if (chk_end)
      cmp("end", 32'(last), 32'(st.block_end));
    if (last && chk_end)
    begin
      cmp("offset", 32'(k), 32'(st.offset));
      cmp("grppos", (k == 4) ? 32'h3 : (k == 3) ? 32'h2 : 32'(k), 32'(st.group_pos));
      cmp("errsyn", 32'(s ^ sy[k]), 32'(es));
      cmp("blkerr", 32'(fl), 32'(st.block_error));
    end
    if (last)
      cmp("lost", 32'(exp_lost), 32'(st.sync_lost));
  endtask
  // One coded block, oldest bit first; fl spoils one check bit
  task automatic blk(int k, logic [15:0] m, logic fl);
    logic [25:0] c;
    c = {m, div({m, 10'h000}, 16) ^ ow[k]};
    c[3] = c[3] ^ fl;
    for (int i = 25; i >= 0; i--)
      bit_out(c[i], k, i == 0, fl);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (16) @(posedge clk);
    cmp("reset", 32'h0, 32'({mp, st, es}));
    rst <= 1'b0;
    for (int g = 0; g < 2; g++)
      for (int j = 0; j < 4; j++)
      begin
        chk_end = (g > 0);
        blk(j == 3 ? 4 : (j == 2 && g > 0) ? 3 : j, 16'h3A5C + 16'(j * 4661), 1'b0);
      end
    cmp("synced", 32'h1, 32'(st.synced));
    @(posedge clk);
    sidv <= 1'b1;
    // Stray extra bit, then A carrying the station identifier one bit late
    chk_end = 1'b0;
    bit_out(1'b0, 0, 1'b0, 1'b0);
    exp_slip = 1'b1;
    blk(0, sid, 1'b0);
    exp_slip = 1'b0;
    cmp("slip_end", 32'h1, 32'(st.block_end));
    cmp("slip_off", 32'(OFF_A), 32'(st.offset));
    chk_end = 1'b1;
    blk(1, 16'h1234, 1'b0);
    blk(2, 16'h8421, 1'b0);
    blk(4, 16'hE00D, 1'b0);
    blk(0, 16'hC3C3, 1'b1);
    blk(1, 16'h0F0F, 1'b0);
    chk_end = 1'b0;
    exp_lost = 1'b1;
    blk(2, 16'h5555, 1'b1);
    exp_lost = 1'b0;
    @(posedge clk);
    #1;
    cmp("synced", 32'h0, 32'(st.synced));
    DEM.send(1'b0, 0);
    DEM.send(1'b1, 0);
    @(posedge clk);
    #1;
    cmp("overrun", 32'h1, 32'(st.overrun));
    repeat (40) @(posedge clk);
    final_report;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      err_count++;
      final_report;
    end
  end
endmodule
